// >>> design/acfp_top.sv
// compare and filter post-processing with its Avalon-MM register slave and interrupt
//
// Contract
// - one comparator enable per input 0..19 gates that input into the comparator.
// - enable bits sit in 19..0; bits 31..20 read as zero.
// - each comparator holds high limit in 31..16, low limit in 15..0.
// - filter_on bit 31 runs the filter; clear disables and forces ready low.
// - bit 30 picks 16 or 12 significant bits in fractional averaging.
// - mode bit picks averaging when set, oversampling when clear.
// - oversampling codes 000..011 sum 4/16/64/256, shift 1..4.
// - oversampling codes 100..111 sum 2/8/32/128, shift 0..3.
// - averaging codes 000..111 average 2 up to 256 samples.
// - bit 25 lets each completed filter result raise the filter interrupt.
// - ready bit 24 set on result, cleared by result read or disable.
// - select field 20..16 picks inputs 0..11; higher codes reserved.
// - stored result keeps its format when the format setting later changes.
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps
`include "acfp_defs.svh"
module acfp_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        conv_valid,
  input  wire logic [4:0]  conv_input,
  input  wire logic [15:0] conv_data,
  input  wire logic        conv_signed,
  input  wire logic        conv_fractional_format,
  output logic [1:0]       cmp_event,
  output logic             irq
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic less_than(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    if (sgn)
      less_than = $signed(a) < $signed(b);
    else
      less_than = a < b;
  endfunction : less_than

  function automatic acfp_pkg::acfp_word_t lane_merge(input acfp_pkg::acfp_word_t old_v,
                                                      input acfp_pkg::acfp_word_t new_v,
                                                      input logic [3:0] be);
    lane_merge = old_v;
    for (int b = 0; b < 4; b++)
      if (be[b])
        lane_merge[b*8 +: 8] = new_v[b*8 +: 8];
  endfunction : lane_merge

  // ****************************************
  // bus handshake
  // ****************************************
  logic                 wait_d;
  acfp_pkg::acfp_word_t rdata_d;
  logic                 bus_req, fire_wr, fire_rd, aligned;
  logic [3:0]           widx;
  acfp_pkg::acfp_word_t rmux;

  logic [19:0]          cmpen_q   [2];
  logic [19:0]          cmpen_d   [2];
  acfp_pkg::acfp_word_t limit_q   [2];
  acfp_pkg::acfp_word_t limit_d   [2];
  logic [3:0]           cmpctl_q  [2];
  logic [3:0]           cmpctl_d  [2];
  acfp_pkg::acfp_word_t fcfg_q    [2];
  acfp_pkg::acfp_word_t fcfg_d    [2];
  logic [3:0]           status_q, status_d;
  logic [3:0]           mask_q, mask_d;
  logic [1:0]           cmp_event_d;
  logic                 irq_d;
  logic [1:0]           cmp_hit;
  logic [1:0]           flt_ready, flt_done, flt_rd_clear;
  logic [15:0]          flt_result [2];

  assign bus_req = avs_read || avs_write;
  assign fire_wr = avs_write && !avs_waitrequest;
  assign fire_rd = avs_read && !avs_waitrequest;
  assign aligned = avs_address[1:0] == 2'h0;
  assign widx    = avs_address[5:2];

  always_comb
  begin
    rmux = `ACFP_RST_WORD;
    if (aligned)
    begin
      case (widx)
        `ACFP_OFS_CMPEN0:   rmux = {12'h000, cmpen_q[0]};
        `ACFP_OFS_CMPEN1:   rmux = {12'h000, cmpen_q[1]};
        `ACFP_OFS_LIMIT0:   rmux = limit_q[0];
        `ACFP_OFS_LIMIT1:   rmux = limit_q[1];
        `ACFP_OFS_FILTER0:  rmux = (fcfg_q[0] & `ACFP_FLT_WR_MASK) |
                                   {7'h00, flt_ready[0], 8'h00, flt_result[0]};
        `ACFP_OFS_FILTER1:  rmux = (fcfg_q[1] & `ACFP_FLT_WR_MASK) |
                                   {7'h00, flt_ready[1], 8'h00, flt_result[1]};
        `ACFP_OFS_CMPCTL0:  rmux = {28'h000_0000, cmpctl_q[0]};
        `ACFP_OFS_CMPCTL1:  rmux = {28'h000_0000, cmpctl_q[1]};
        `ACFP_OFS_IRQ_STAT: rmux = {28'h000_0000, status_q};
        `ACFP_OFS_IRQ_MASK: rmux = {28'h000_0000, mask_q};
        default:            rmux = `ACFP_RST_WORD;
      endcase
    end
    // one wait cycle, then a single answer cycle
    wait_d  = !(bus_req && avs_waitrequest);
    rdata_d = (bus_req && avs_waitrequest) ? rmux : avs_readdata;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `ACFP_RST_WORD;
    end
    else
    begin
      avs_waitrequest <= wait_d;
      avs_readdata    <= rdata_d;
    end
  end

  // ****************************************
  // channels
  // ****************************************
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_chan
      logic hit_en, below, above_lo, below_hi;
      assign hit_en   = conv_valid && cmpctl_q[i][`ACFP_CTL_ON] &&
                        conv_input <= 5'(`ACFP_IN_LAST) && cmpen_q[i][conv_input];
      assign below    = less_than(conv_data, limit_q[i][15:0], conv_signed);
      assign below_hi = less_than(conv_data, limit_q[i][31:16], conv_signed);
      assign above_lo = !below;
      assign cmp_hit[i] = hit_en && ((cmpctl_q[i][`ACFP_CTL_BELOW] && below) ||
                                     (cmpctl_q[i][`ACFP_CTL_ABOVE] && !below_hi) ||
                                     (cmpctl_q[i][`ACFP_CTL_INSIDE] && above_lo && below_hi));
      // only clear what the captured read word showed as ready
      assign flt_rd_clear[i] = fire_rd && aligned && widx == (`ACFP_OFS_FILTER0 + 4'(i)) &&
                               avs_readdata[`ACFP_FLT_RDY];

      acfp_filter_chan u_filter (
        .clk                 (clk),
        .reset               (reset),
        .filter_on           (fcfg_q[i][`ACFP_FLT_ON]),
        .averaging_select    (fcfg_q[i][`ACFP_FLT_AVG]),
        .sample_ratio        (fcfg_q[i][`ACFP_FLT_RAT_HI:`ACFP_FLT_RAT_LO]),
        .full_width_output   (fcfg_q[i][`ACFP_FLT_FULLW]),
        .fractional_format   (conv_fractional_format),
        .sample_valid        (conv_valid && conv_input == fcfg_q[i][`ACFP_FLT_SEL_HI:`ACFP_FLT_SEL_LO] &&
                              conv_input <= `ACFP_FLT_SEL_MAX),
        .sample_data         (conv_data[11:0]),
        .ready_clear         (flt_rd_clear[i]),
        .filter_result_ready (flt_ready[i]),
        .filter_result       (flt_result[i]),
        .result_done         (flt_done[i])
      );
    end
  endgenerate

  // ****************************************
  // configuration registers
  // ****************************************
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      cmpen_d[i]  = cmpen_q[i];
      limit_d[i]  = limit_q[i];
      cmpctl_d[i] = cmpctl_q[i];
      fcfg_d[i]   = fcfg_q[i];
    end
    mask_d = mask_q;
    if (fire_wr && aligned)
    begin
      case (widx)
        `ACFP_OFS_CMPEN0:   cmpen_d[0]  = 20'(lane_merge({12'h000, cmpen_q[0]}, avs_writedata, avs_byteenable));
        `ACFP_OFS_CMPEN1:   cmpen_d[1]  = 20'(lane_merge({12'h000, cmpen_q[1]}, avs_writedata, avs_byteenable));
        `ACFP_OFS_LIMIT0:   limit_d[0]  = lane_merge(limit_q[0], avs_writedata, avs_byteenable);
        `ACFP_OFS_LIMIT1:   limit_d[1]  = lane_merge(limit_q[1], avs_writedata, avs_byteenable);
        `ACFP_OFS_FILTER0:  fcfg_d[0]   = lane_merge(fcfg_q[0], avs_writedata, avs_byteenable) & `ACFP_FLT_WR_MASK;
        `ACFP_OFS_FILTER1:  fcfg_d[1]   = lane_merge(fcfg_q[1], avs_writedata, avs_byteenable) & `ACFP_FLT_WR_MASK;
        `ACFP_OFS_CMPCTL0:  cmpctl_d[0] = avs_byteenable[0] ? avs_writedata[3:0] : cmpctl_q[0];
        `ACFP_OFS_CMPCTL1:  cmpctl_d[1] = avs_byteenable[0] ? avs_writedata[3:0] : cmpctl_q[1];
        `ACFP_OFS_IRQ_MASK: mask_d      = avs_byteenable[0] ? avs_writedata[3:0] : mask_q;
        default:            mask_d      = mask_q;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 2; i++)
      begin
        cmpen_q[i]  <= 20'h0_0000;
        limit_q[i]  <= `ACFP_RST_WORD;
        cmpctl_q[i] <= 4'h0;
        fcfg_q[i]   <= `ACFP_RST_WORD;
      end
      mask_q <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        cmpen_q[i]  <= cmpen_d[i];
        limit_q[i]  <= limit_d[i];
        cmpctl_q[i] <= cmpctl_d[i];
        fcfg_q[i]   <= fcfg_d[i];
      end
      mask_q <= mask_d;
    end
  end

  // ****************************************
  // events and interrupt
  // ****************************************
  always_comb
  begin
    cmp_event_d = cmp_hit;
    status_d    = status_q;
    // read clears only bits seen in the captured word; new events still win
    if (fire_rd && aligned && widx == `ACFP_OFS_IRQ_STAT)
      status_d = status_q & ~avs_readdata[3:0];
    status_d = status_d | {flt_done & {fcfg_q[1][`ACFP_FLT_IRQEN], fcfg_q[0][`ACFP_FLT_IRQEN]}, cmp_hit};
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cmp_event <= 2'h0;
      status_q  <= 4'h0;
      irq       <= 1'b0;
    end
    else
    begin
      cmp_event <= cmp_event_d;
      status_q  <= status_d;
      irq       <= irq_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_req_waiting;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_req_waiting |=> s_answer)
    else $error("slave did not answer in one wait cycle");
  a_cmpen_upper_zero: assert property (fire_rd && aligned && widx == `ACFP_OFS_CMPEN0
    |-> avs_readdata[31:20] == 12'h000)
    else $error("comparator enable upper bits not zero");
  a_limit_store: assert property (fire_wr && aligned && widx == `ACFP_OFS_LIMIT0
    && avs_byteenable == 4'hF |=> limit_q[0] == $past(avs_writedata))
    else $error("limit write not stored");
  a_cmp_gate: assert property (conv_valid && conv_input <= 5'(`ACFP_IN_LAST) && !cmpen_q[0][conv_input]
    |=> !cmp_event[0])
    else $error("disabled input raised a comparator event");
  a_cmp_below: assert property (conv_valid && cmpctl_q[0] == 4'h3 && conv_input <= 5'(`ACFP_IN_LAST) &&
    cmpen_q[0][conv_input] && !conv_signed && conv_data < limit_q[0][15:0] |=> cmp_event[0] ##1 status_q[0])
    else $error("result below low limit missed");
  a_status_set_wins: assert property (cmp_hit[0] |=> status_q[0])
    else $error("comparator event lost against a clear");
  a_flt_irq_gate: assert property (flt_done[0] && !fcfg_q[0][`ACFP_FLT_IRQEN] && !status_q[2] |=> !status_q[2])
    else $error("filter interrupt raised while disabled");
  a_irq_level: assert property (irq == |(status_q & mask_q))
    else $error("interrupt output disagrees with status and mask");
  a_cmpen1_upper_zero: assert property (fire_rd && aligned && widx == `ACFP_OFS_CMPEN1
    |-> avs_readdata[31:20] == 12'h000)
    else $error("second comparator enable upper bits not zero");
  a_cmp_refused: assert property (conv_valid && conv_input > 5'(`ACFP_IN_LAST)
    |=> cmp_event == 2'h0)
    else $error("input beyond the last one raised a comparator event");
  a_cmp_off_quiet: assert property (!cmpctl_q[1][`ACFP_CTL_ON]
    |=> !cmp_event[1])
    else $error("stopped comparator raised an event");
  a_flt1_off_ready: assert property (!fcfg_q[1][`ACFP_FLT_ON]
    |=> !flt_ready[1])
    else $error("second filter ready flag survived a disable");
  a_flt1_irq_set: assert property (flt_done[1] && fcfg_q[1][`ACFP_FLT_IRQEN]
    |=> status_q[3])
    else $error("filter completion not recorded in status");
  a_flt1_read_clear: assert property (fire_rd && aligned && widx == `ACFP_OFS_FILTER1
    && avs_readdata[`ACFP_FLT_RDY] |=> !flt_ready[1] || flt_done[1])
    else $error("ready flag not cleared by a result read");
  a_status_read_clear: assert property (fire_rd && aligned && widx == `ACFP_OFS_IRQ_STAT
    && avs_readdata[0] && !cmp_hit[0] |=> !status_q[0])
    else $error("status bit survived its clearing read");
endmodule : acfp_top

// >>> design/acfp_defs.svh
// register map, field positions, reset values and codes for the compare and filter block
`ifndef ACFP_DEFS_SVH
`define ACFP_DEFS_SVH
// ****************************************
// register word offsets, matched against address bits 5:2
// ****************************************
`define ACFP_OFS_CMPEN0    4'h0
`define ACFP_OFS_CMPEN1    4'h1
`define ACFP_OFS_LIMIT0    4'h2
`define ACFP_OFS_LIMIT1    4'h3
`define ACFP_OFS_FILTER0   4'h4
`define ACFP_OFS_FILTER1   4'h5
`define ACFP_OFS_CMPCTL0   4'h6
`define ACFP_OFS_CMPCTL1   4'h7
`define ACFP_OFS_IRQ_STAT  4'h8
`define ACFP_OFS_IRQ_MASK  4'h9
// ****************************************
// fields
// ****************************************
`define ACFP_RST_WORD      32'h0000_0000
`define ACFP_CMPEN_MASK    32'h000F_FFFF
`define ACFP_FLT_WR_MASK   32'hFE1F_0000
`define ACFP_FLT_ON        31
`define ACFP_FLT_FULLW     30
`define ACFP_FLT_AVG       29
`define ACFP_FLT_RAT_HI    28
`define ACFP_FLT_RAT_LO    26
`define ACFP_FLT_IRQEN     25
`define ACFP_FLT_RDY       24
`define ACFP_FLT_SEL_HI    20
`define ACFP_FLT_SEL_LO    16
`define ACFP_FLT_SEL_MAX   5'h0B
`define ACFP_CTL_ON        0
`define ACFP_CTL_BELOW     1
`define ACFP_CTL_ABOVE     2
`define ACFP_CTL_INSIDE    3
`define ACFP_IN_LAST       19
`define ACFP_OSR_BASE_W    5'h0D
`define ACFP_OUT_W         5'h10
`endif

// >>> design/acfp_pkg.sv
// shared types of the compare and filter block
package acfp_pkg;
  typedef logic [31:0] acfp_word_t;
  typedef enum logic [1:0] {
    FLT_IDLE = 2'b01,
    FLT_RUN  = 2'b10
  } acfp_flt_state_e;
endpackage : acfp_pkg

// >>> design/acfp_filter_chan.sv
// one filter channel: oversampling or averaging accumulator with result and ready flag
`timescale 1ns/1ps
`include "acfp_defs.svh"
module acfp_filter_chan (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        filter_on,
  input  wire logic        averaging_select,
  input  wire logic [2:0]  sample_ratio,
  input  wire logic        full_width_output,
  input  wire logic        fractional_format,
  input  wire logic        sample_valid,
  input  wire logic [11:0] sample_data,
  input  wire logic        ready_clear,
  output logic             filter_result_ready,
  output logic [15:0]      filter_result,
  output logic             result_done
);
  // ****************************************
  // next state
  // ****************************************
  acfp_pkg::acfp_flt_state_e state_q, state_d;
  logic [19:0] acc_q, acc_d, sum;
  logic [8:0]  cnt_q, cnt_d, total;
  logic [3:0]  log2n;
  logic [2:0]  osr_shift;
  logic [4:0]  osr_width;
  logic [15:0] os_val, res_new, res_d;
  logic [11:0] avg12;
  logic        rdy_d, done_d;

  always_comb
  begin
    // averaging doubles per code from 2; oversampling follows the ratio table
    if (averaging_select)
      log2n = {1'b0, sample_ratio} + 4'h1;
    else if (sample_ratio[2])
      log2n = {1'b0, sample_ratio[1:0], 1'b1};
    else
      log2n = {1'b0, sample_ratio[1:0], 1'b0} + 4'h2;
    osr_shift = sample_ratio[2] ? {1'b0, sample_ratio[1:0]} : {1'b0, sample_ratio[1:0]} + 3'h1;
    osr_width = `ACFP_OSR_BASE_W + {3'h0, sample_ratio[1:0]};
    total     = 9'h001 << log2n;
    sum       = acc_q + {8'h00, sample_data};
    avg12     = 12'(sum >> log2n);
    os_val    = 16'(sum >> osr_shift);
    if (averaging_select)
    begin
      if (fractional_format && full_width_output)
        res_new = 16'({sum, 4'h0} >> log2n);
      else if (fractional_format)
        res_new = {avg12, 4'h0};
      else
        res_new = {4'h0, avg12};
    end
    else if (fractional_format)
      res_new = 16'(os_val << (`ACFP_OUT_W - osr_width));
    else
      res_new = os_val;
    state_d = state_q;
    acc_d   = acc_q;
    cnt_d   = cnt_q;
    res_d   = filter_result;
    done_d  = 1'b0;
    case (state_q)
      acfp_pkg::FLT_IDLE:
      begin
        acc_d = 20'h0_0000;
        cnt_d = 9'h000;
        if (filter_on)
          state_d = acfp_pkg::FLT_RUN;
      end
      acfp_pkg::FLT_RUN:
      begin
        if (!filter_on)
          state_d = acfp_pkg::FLT_IDLE;
        else if (sample_valid)
        begin
          if (cnt_q + 9'h001 == total)
          begin
            res_d  = res_new;
            done_d = 1'b1;
            acc_d  = 20'h0_0000;
            cnt_d  = 9'h000;
          end
          else
          begin
            acc_d = sum;
            cnt_d = cnt_q + 9'h001;
          end
        end
      end
      default:
        state_d = acfp_pkg::FLT_IDLE;
    endcase
    // set wins over a read clear; disabling clears outright
    rdy_d = filter_result_ready;
    if (ready_clear)
      rdy_d = 1'b0;
    if (done_d)
      rdy_d = 1'b1;
    if (!filter_on)
      rdy_d = 1'b0;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q             <= acfp_pkg::FLT_IDLE;
      acc_q               <= 20'h0_0000;
      cnt_q               <= 9'h000;
      filter_result       <= 16'h0000;
      filter_result_ready <= 1'b0;
      result_done         <= 1'b0;
    end
    else
    begin
      state_q             <= state_d;
      acc_q               <= acc_d;
      cnt_q               <= cnt_d;
      filter_result       <= res_d;
      filter_result_ready <= rdy_d;
      result_done         <= done_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_off_clears_ready: assert property (!filter_on |=> !filter_result_ready)
    else $error("ready flag survived a disabled filter");
  a_done_sets_ready: assert property (result_done && filter_on |-> filter_result_ready)
    else $error("result completed without ready flag");
  a_restart_count: assert property (result_done |-> cnt_q == 9'h000 && acc_q == 20'h0_0000)
    else $error("accumulator not restarted after output");
  a_avg_int_narrow: assert property (result_done && $past(averaging_select) && !$past(fractional_format)
    |-> filter_result[15:12] == 4'h0)
    else $error("averaged integer result wider than twelve bits");
  a_osr_int_width: assert property (result_done && !$past(averaging_select) && !$past(fractional_format)
    |-> (filter_result >> $past(osr_width)) == 16'h0000)
    else $error("oversampled result exceeds its width");
endmodule : acfp_filter_chan

// >>> verif/acfp_conv_model.sv
// conversion core model that feeds results into the block
`timescale 1ns/1ps
// ****************************************
// result source
// ****************************************
module acfp_conv_model (
  input  wire logic  clk,
  output logic        conv_valid,
  output logic [4:0]  conv_input,
  output logic [15:0] conv_data,
  output logic        conv_signed,
  output logic        conv_fractional_format
);
  initial
  begin
    conv_valid = 1'b0;
    conv_input = 5'h1F;
    conv_data = 16'h0000;
    conv_signed = 1'b0;
    conv_fractional_format = 1'b0;
  end
  // result format levels, changed just after an edge
  task automatic set_format(input logic sgn, input logic fr);
    conv_signed <= sgn;
    conv_fractional_format <= fr;
  endtask : set_format
  // one-cycle result pulse; lines scrambled once it is over
  task automatic send(input logic [4:0] inp, input logic [15:0] dat);
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_input <= inp;
    conv_data <= dat;
    @(posedge clk);
    conv_valid <= 1'b0;
    conv_input <= ~inp;
    conv_data <= ~dat;
  endtask : send
endmodule : acfp_conv_model

// >>> verif/tb_acfp_top.sv
// self-checking bench for the compare and filter block
`timescale 1ns/1ps
// ****************************************
// bench
// ****************************************
module tb_acfp_top;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        conv_valid;
  logic [4:0]  conv_input;
  logic [15:0] conv_data;
  logic        conv_signed;
  logic        conv_fractional_format;
  logic [1:0]  cmp_event;
  logic        irq;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          n;
  int          sh;
  logic [31:0] rd;
  logic [31:0] cfg;
  logic [31:0] sum;
  logic [31:0] ex;
  logic [11:0] smp;
  always #12.5 clk = ~clk;
  acfp_top u_acfp_top (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conv_valid(conv_valid),
    .conv_input(conv_input), .conv_data(conv_data), .conv_signed(conv_signed), .conv_fractional_format(conv_fractional_format),
    .cmp_event(cmp_event), .irq(irq));
  acfp_conv_model u_acfp_conv_model (.clk(clk), .conv_valid(conv_valid), .conv_input(conv_input),
    .conv_data(conv_data), .conv_signed(conv_signed), .conv_fractional_format(conv_fractional_format));
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk
  task automatic evchk(input logic [4:0] inp, input logic [15:0] d, input logic [1:0] exp);
    u_acfp_conv_model.send(inp, d);
    #1;
    check({30'h0, cmp_event}, {30'h0, exp});
  endtask : evchk
  task automatic run_filter(input logic fr, input logic avg, input logic [2:0] c);
    n = avg ? (2 << c) : (c[2] ? (2 << (2 * c[1:0])) : (4 << (2 * c[1:0])));
    sh = avg ? c + 1 : (c[2] ? c[1:0] : c[1:0] + 1);
    cfg = {1'b1, c[0], avg, c, 1'b1, 1'b0, 3'b000, 5'h05, 16'h0000};
    sum = 32'h0000_0000;
    u_acfp_conv_model.set_format(1'b1, fr);
    bus(1'b1, 6'h10, cfg);
    for (int k = 0; k < n; k++)
    begin
      smp = 12'h9C1 + 12'(k * 37);
      sum += {20'h0, smp};
      u_acfp_conv_model.send(5'h05, {4'h0, smp});
      if (k == 0) u_acfp_conv_model.send(5'h06, 16'h0FFF);
    end
    if (!fr) ex = sum >> sh;
    else if (avg) ex = c[0] ? (sum << 4) >> sh : (sum >> sh) << 4;
    else ex = (sum >> sh) << (3 - c[1:0]);
    @(posedge clk);
    u_acfp_conv_model.set_format(1'b1, ~fr);
    rdchk(6'h10, cfg | 32'h0100_0000 | {16'h0, ex[15:0]});
    rdchk(6'h20, 32'h0000_0004);
    rdchk(6'h10, cfg | {16'h0, ex[15:0]});
    bus(1'b1, 6'h10, 32'h0000_0000);
  endtask : run_filter
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      conclude();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 11; a++) rdchk(6'(a * 4), 32'h0000_0000);
    bus(1'b1, 6'h28, 32'hFFFF_FFFF);
    bus(1'b1, 6'h09, 32'hFFFF_FFFF);
    rdchk(6'h28, 32'h0000_0000);
    rdchk(6'h08, 32'h0000_0000);
    bus(1'b1, 6'h00, 32'hFFFF_FFFF);
    rdchk(6'h00, 32'h000F_FFFF);
    bus(1'b1, 6'h00, 32'h0000_0008);
    bus(1'b1, 6'h04, 32'h0008_0000);
    bus(1'b1, 6'h08, 32'h0100_0080);
    rdchk(6'h08, 32'h0100_0080);
    bus(1'b1, 6'h0C, 32'hFFC0_8000);
    rdchk(6'h0C, 32'hFFC0_8000);
    bus(1'b1, 6'h24, 32'h0000_0001);
    bus(1'b1, 6'h18, 32'h0000_0003);
    evchk(5'h03, 16'h0010, 2'b01);
    @(posedge clk);
    #1 check({31'h0, irq}, 32'h1);
    rdchk(6'h20, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1 check({31'h0, irq}, 32'h0);
    evchk(5'h04, 16'h0010, 2'b00);
    evchk(5'h03, 16'h0100, 2'b00);
    u_acfp_conv_model.set_format(1'b1, 1'b0);
    bus(1'b1, 6'h1C, 32'h0000_0005);
    evchk(5'h13, 16'h0010, 2'b10);
    evchk(5'h14, 16'h0010, 2'b00);
    #1 check({31'h0, irq}, 32'h0);
    rdchk(6'h20, 32'h0000_0002);
    bus(1'b1, 6'h18, 32'h0000_0000);
    bus(1'b1, 6'h18, 32'h0000_0009);
    evchk(5'h03, 16'h00C0, 2'b01);
    evchk(5'h03, 16'h0100, 2'b00);
    bus(1'b1, 6'h18, 32'h0000_0000);
    bus(1'b1, 6'h1C, 32'h0000_0000);
    rdchk(6'h20, 32'h0000_0001);
    for (int m = 0; m < 32; m++) run_filter(m[4], m[3], m[2:0]);
    u_acfp_conv_model.set_format(1'b1, 1'b0);
    bus(1'b1, 6'h10, 32'h9000_0000 | 32'h0005_0000);
    repeat (2) u_acfp_conv_model.send(5'h05, 16'h0123);
    bus(1'b1, 6'h10, 32'h0000_0000);
    rdchk(6'h10, 32'h0000_0246);
    bus(1'b1, 6'h10, 32'h900C_0000);
    repeat (2) u_acfp_conv_model.send(5'h0C, 16'h0123);
    bus(1'b0, 6'h10, 32'h0000_0000);
    check(rd, 32'h900C_0246);
    bus(1'b1, 6'h10, 32'h0000_0000);
    // second filter channel: two-sample average, interrupt enabled
    bus(1'b1, 6'h14, 32'hA202_0000);
    u_acfp_conv_model.send(5'h02, 16'h0100);
    u_acfp_conv_model.send(5'h02, 16'h0102);
    rdchk(6'h14, 32'hA302_0101);
    rdchk(6'h20, 32'h0000_0008);
    bus(1'b1, 6'h14, 32'h0000_0000);
    rdchk(6'h14, 32'h0000_0101);
    // low half only of the first limit word
    avs_byteenable <= 4'h3;
    bus(1'b1, 6'h08, 32'hAAAA_0040);
    avs_byteenable <= 4'hF;
    rdchk(6'h08, 32'h0100_0040);
    conclude();
  end
endmodule : tb_acfp_top
